// ### design/mac_slice.sv
// Purpose: signed 25x18 multiply-accumulate slice with pre-adder, simd alu and pattern detector
// Assumes: all inputs but RESETN come from logic on SYS_CLK, so only the release of RESETN is synchronised
// Notes: RST_SYNC clears the datapath; RESETN is the power-on reset
`timescale 1ns/100ps
// Operation
// RULE1: signed 25 by 18 full product
// RULE2: 48-bit accumulator adds each result
// RULE3: multiplier bypass feeds two 48-bit operands
// RULE4: simd two 24 or four 12-bit lanes
// RULE5: logic unit with ten bitwise functions
// RULE6: pre-adder combines operands before multiplying
// RULE7: pattern detector on result aids rounding
// RULE8: detector with logic unit spans 96 bits
// RULE9: pipeline registers and alu stage optional
// RULE10: cascade buses to adjacent slices
// RULE11: accumulator counts up or down
// RULE12: registers update on enable, sync clear
// RULE13: fabric keeps controls aligned with operands
module mac_slice #(
  parameter bit AREG = 1'b1,
  parameter bit BREG = 1'b1,
  parameter bit CREG = 1'b1,
  parameter bit MREG = 1'b1,
  parameter bit USE_ALU = 1'b1,
  parameter logic [47:0] PATTERN = 48'h0,
  parameter logic [47:0] MASK = 48'h0
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic RST_SYNC,
  input wire mac_slice_pkg::ctrl_s CTRL,
  input wire mac_slice_pkg::ce_s CE,
  input wire logic [24:0] A_IN,
  input wire logic [24:0] D_IN,
  input wire logic [17:0] B_IN,
  input wire logic [47:0] C_IN,
  input wire logic [24:0] ACIN,
  input wire logic [47:0] PCIN,
  input wire logic PDET_CASC_IN,
  output logic [47:0] P_OUT,
  output logic [47:0] PCOUT,
  output logic [24:0] ACOUT,
  output logic [17:0] BCOUT,
  output logic PDET_OUT,
  output logic PDET_WIDE_OUT
);
  localparam logic PDET_RST = ((mac_slice_pkg::P_RST ^ PATTERN) & ~MASK) == 48'h0;

  logic rst_meta_reg;
  logic rst_n;
  logic [24:0] a_reg;
  logic [24:0] d_reg;
  logic [17:0] b_reg;
  logic [47:0] c_reg;
  logic [43:0] m_reg;
  logic [47:0] p_reg;
  logic pdet_reg;
  logic wide_reg;
  logic [24:0] a_src;
  logic [24:0] a_use;
  logic [24:0] d_use;
  logic [17:0] b_use;
  logic [47:0] c_use;
  logic [25:0] pre_sum;
  logic [43:0] prod_next;
  logic [43:0] m_use;
  logic [47:0] x_op;
  logic [47:0] z_op;
  logic [47:0] p_next;
  logic match_next;

  // every check shares the slice clock and sleeps until the released reset
  default clocking dflt_cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  // lane-split add or subtract: carries stop at each active lane boundary
  function automatic logic [47:0] simd_addsub(input logic [47:0] z, input logic [47:0] x,
                                              input logic sub, input mac_slice_pkg::simd_e mode);
    logic [47:0] r;
    logic [12:0] s;
    logic c;
    r = 48'h0;
    c = sub;
    for (int i = 0; i < mac_slice_pkg::LANES; i++)
    begin
      if ((i == 2 && mode != mac_slice_pkg::SIMD_ONE48) ||
          (i[0] && mode == mac_slice_pkg::SIMD_FOUR12))
        c = sub;
      s = {1'b0, z[i*12 +: 12]} + {1'b0, (sub ? ~x[i*12 +: 12] : x[i*12 +: 12])} + {12'h0, c};
      r[i*12 +: 12] = s[11:0];
      c = s[12];
    end
    return r;
  endfunction

  function automatic logic [47:0] logic_unit(input logic [47:0] x, input logic [47:0] z,
                                             input mac_slice_pkg::logic_fn_e fn);
    logic [47:0] r;
    r = 48'h0;
    case (fn)
      mac_slice_pkg::LF_AND: r = x & z;
      mac_slice_pkg::LF_OR: r = x | z;
      mac_slice_pkg::LF_XOR: r = x ^ z;
      mac_slice_pkg::LF_XNOR: r = ~(x ^ z);
      mac_slice_pkg::LF_NAND: r = ~(x & z);
      mac_slice_pkg::LF_NOR: r = ~(x | z);
      mac_slice_pkg::LF_AND_NZ: r = x & ~z;
      mac_slice_pkg::LF_OR_NZ: r = x | ~z;
      mac_slice_pkg::LF_NOT_X: r = ~x;
      mac_slice_pkg::LF_PASS_X: r = x;
      default: r = 48'h0;
    endcase
    return r;
  endfunction

  // reset release through two flops; assertion is immediate, release is clocked
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // operand stage; registers hold without enable, clear on sync reset
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_reg <= mac_slice_pkg::A_RST;
      d_reg <= mac_slice_pkg::A_RST;
      b_reg <= mac_slice_pkg::B_RST;
      c_reg <= mac_slice_pkg::P_RST;
    end
    else if (RST_SYNC) // [RULE12]
    begin
      a_reg <= mac_slice_pkg::A_RST;
      d_reg <= mac_slice_pkg::A_RST;
      b_reg <= mac_slice_pkg::B_RST;
      c_reg <= mac_slice_pkg::P_RST;
    end
    else
    begin
      if (CE.ce_a) // [RULE12]
      begin
        a_reg <= a_src;
        d_reg <= D_IN;
      end
      if (CE.ce_b)
        b_reg <= B_IN;
      if (CE.ce_c)
        c_reg <= C_IN;
    end
  end

  // a may come from the neighbour's cascade bus instead of general routing
  assign a_src = CTRL.a_casc ? ACIN : A_IN; // [RULE10]
  // each stage can be skipped to trade latency for speed
  assign a_use = AREG ? a_reg : a_src; // [RULE9]
  assign d_use = AREG ? d_reg : D_IN;
  assign b_use = BREG ? b_reg : B_IN;
  assign c_use = CREG ? c_reg : C_IN;

  // pre-adder widened by one bit so a symmetric tap sum never overflows
  assign pre_sum = !CTRL.preadd_en ? {a_use[24], a_use} :
                   CTRL.preadd_sub ? 26'($signed(d_use) - $signed(a_use)) :
                   26'($signed(d_use) + $signed(a_use)); // [RULE6]
  assign prod_next = 44'($signed(pre_sum) * $signed(b_use)); // [RULE1]

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      m_reg <= 44'h0;
    else if (RST_SYNC)
      m_reg <= 44'h0;
    else if (CE.ce_m)
      m_reg <= prod_next;
  end
  assign m_use = MREG ? m_reg : prod_next; // [RULE9]

  // bypass joins a and b into one 48-bit operand in place of the product
  always_comb
  begin
    if (CTRL.mul_bypass) // [RULE3]
      x_op = 48'($signed({a_use, b_use}));
    else
      x_op = 48'($signed(m_use));
    case (CTRL.zsel)
      mac_slice_pkg::Z_ACC: z_op = p_reg; // [RULE2]
      mac_slice_pkg::Z_CIN: z_op = c_use;
      mac_slice_pkg::Z_CASC: z_op = PCIN; // [RULE10]
      default: z_op = 48'h0;
    endcase
  end

  // alu: arithmetic is z plus or minus x; counters ignore the lane split
  always_comb
  begin
    p_next = x_op;
    if (USE_ALU) // [RULE9]
    begin
      case (CTRL.op)
        mac_slice_pkg::OP_ADD: p_next = simd_addsub(z_op, x_op, 1'b0, CTRL.simd); // [RULE4]
        mac_slice_pkg::OP_SUB: p_next = simd_addsub(z_op, x_op, 1'b1, CTRL.simd); // [RULE4]
        mac_slice_pkg::OP_LOGIC: p_next = logic_unit(x_op, z_op, CTRL.logic_fn); // [RULE5]
        mac_slice_pkg::OP_CNT_UP: p_next = p_reg + 48'h1; // [RULE11]
        mac_slice_pkg::OP_CNT_DN: p_next = p_reg - 48'h1; // [RULE11]
        default: p_next = x_op;
      endcase
    end
  end

  // masked compare; a tie pattern on the low bits flags convergent rounding
  assign match_next = ((p_next ^ PATTERN) & ~MASK) == 48'h0; // [RULE7]

  // result stage: detector flag is registered with the result it describes
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p_reg <= mac_slice_pkg::P_RST;
      pdet_reg <= PDET_RST;
      wide_reg <= 1'b0;
    end
    else if (RST_SYNC) // [RULE12]
    begin
      p_reg <= mac_slice_pkg::P_RST;
      pdet_reg <= PDET_RST;
      wide_reg <= 1'b0;
    end
    else if (CE.ce_p)
    begin
      p_reg <= p_next;
      pdet_reg <= match_next; // [RULE7]
      wide_reg <= match_next & PDET_CASC_IN; // [RULE8]
    end
  end

  assign P_OUT = p_reg;
  assign PCOUT = p_reg; // [RULE10]
  assign ACOUT = a_reg;
  assign BCOUT = b_reg;
  assign PDET_OUT = pdet_reg;
  assign PDET_WIDE_OUT = wide_reg;

  // steps only count when the alu stage is built in
  sequence acc_step_s;
    USE_ALU && CE.ce_p && !RST_SYNC && CTRL.op == mac_slice_pkg::OP_ADD;
  endsequence
  sequence cnt_up_s;
    USE_ALU && CE.ce_p && !RST_SYNC && CTRL.op == mac_slice_pkg::OP_CNT_UP;
  endsequence

  mult_full_a: assert property (CE.ce_m && !RST_SYNC && !CTRL.preadd_en |=> // [RULE1]
    m_reg == 44'($past($signed(a_use)) * $past($signed(b_use))))
    else $error("product does not match operands");
  preadd_prod_a: assert property (CE.ce_m && !RST_SYNC && CTRL.preadd_en &&
    !CTRL.preadd_sub |=> m_reg == 44'(($past($signed(d_use)) + // [RULE6]
    $past($signed(a_use))) * $past($signed(b_use))))
    else $error("pre-added product wrong");
  accum_step_a: assert property (acc_step_s and CTRL.zsel == mac_slice_pkg::Z_ACC && // [RULE2]
    CTRL.simd == mac_slice_pkg::SIMD_ONE48 |=> p_reg == $past(p_reg) + $past(x_op))
    else $error("accumulator did not add");
  bypass_path_a: assert property (acc_step_s and CTRL.mul_bypass && // [RULE3]
    CTRL.zsel == mac_slice_pkg::Z_ZERO |=> p_reg == 48'($past($signed({a_use, b_use}))))
    else $error("bypass operand not passed");
  simd_lane_a: assert property (acc_step_s and // [RULE4]
    CTRL.simd == mac_slice_pkg::SIMD_FOUR12 |=>
    p_reg[23:12] == $past(x_op[23:12]) + $past(z_op[23:12]))
    else $error("carry crossed a lane");
  logic_and_a: assert property (USE_ALU && CE.ce_p && !RST_SYNC && // [RULE5]
    CTRL.op == mac_slice_pkg::OP_LOGIC && CTRL.logic_fn == mac_slice_pkg::LF_AND |=>
    p_reg == ($past(x_op) & $past(z_op)))
    else $error("logic and wrong");
  pattern_flag_a: assert property (PDET_OUT == (((P_OUT ^ PATTERN) & ~MASK) == 48'h0)) // [RULE7]
    else $error("detector disagrees with result");
  wide_logic_a: assert property (CE.ce_p && !RST_SYNC |=> // [RULE8]
    PDET_WIDE_OUT == (PDET_OUT && $past(PDET_CASC_IN)))
    else $error("wide detect wrong");
  cascade_out_a: assert property (acc_step_s and CTRL.zsel == mac_slice_pkg::Z_CASC && // [RULE10]
    CTRL.simd == mac_slice_pkg::SIMD_ONE48 |=> PCOUT == $past(PCIN) + $past(x_op))
    else $error("cascade sum wrong");
  count_up_a: assert property (cnt_up_s ##1 cnt_up_s |=> // [RULE11]
    p_reg == $past(p_reg, 2) + 48'h2)
    else $error("counter did not step");
  sync_clear_a: assert property (RST_SYNC |=> P_OUT == 48'h0 && m_reg == 44'h0) // [RULE12]
    else $error("sync reset did not clear");
  hold_idle_a: assert property (!CE.ce_p && !RST_SYNC |=> $stable(P_OUT)) // [RULE12]
    else $error("result changed without enable");
endmodule

// ### design/mac_slice_pkg.sv
// Purpose: shared types and constants of the multiply-accumulate slice
// Assumes: one clock domain; fabric drives controls in step with operands
// Notes: enum codes, except the binary logic functions, follow a gray order along the usual operation path
package mac_slice_pkg;
  localparam int A_W = 25;
  localparam int B_W = 18;
  localparam int P_W = 48;
  localparam int LANE_W = 12;
  localparam int LANES = 4;
  localparam int PRE_W = 26;
  localparam int PROD_W = 44;
  localparam logic [47:0] P_RST = 48'h0;
  localparam logic [24:0] A_RST = 25'h0;
  localparam logic [17:0] B_RST = 18'h0;

  // add and subtract share the arithmetic path; counters reuse the accumulator
  typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_SUB = 3'h1,
    OP_LOGIC = 3'h3,
    OP_CNT_UP = 3'h2,
    OP_CNT_DN = 3'h6
  } alu_op_e;

  typedef enum logic [1:0] {
    Z_ZERO = 2'h0,
    Z_ACC = 2'h1,
    Z_CIN = 2'h3,
    Z_CASC = 2'h2
  } zsel_e;

  typedef enum logic [1:0] {
    SIMD_ONE48 = 2'h0,
    SIMD_TWO24 = 2'h1,
    SIMD_FOUR12 = 2'h3
  } simd_e;

  // ten bitwise functions of x and z
  typedef enum logic [3:0] {
    LF_AND = 4'h0,
    LF_OR = 4'h1,
    LF_XOR = 4'h2,
    LF_XNOR = 4'h3,
    LF_NAND = 4'h4,
    LF_NOR = 4'h5,
    LF_AND_NZ = 4'h6,
    LF_OR_NZ = 4'h7,
    LF_NOT_X = 4'h8,
    LF_PASS_X = 4'h9
  } logic_fn_e;

  typedef struct packed {
    logic a_casc;
    logic preadd_en;
    logic preadd_sub;
    logic mul_bypass;
    zsel_e zsel;
    alu_op_e op;
    simd_e simd;
    logic_fn_e logic_fn;
  } ctrl_s;

  typedef struct packed {
    logic ce_a;
    logic ce_b;
    logic ce_c;
    logic ce_m;
    logic ce_p;
  } ce_s;
endpackage

// ### verification/nbr_slice.sv
// Purpose: behavioural neighbour slice feeding the cascade inputs
// Assumes: shares the clock of the slice under test
// Notes: its flag is a zero match of the loaded value, as a slice with default pattern
`timescale 1ns/100ps
module nbr_slice (
  input wire logic clk,
  input wire logic load,
  input wire logic [47:0] val,
  output logic [47:0] pc = 48'h0,
  output logic [24:0] ac = 25'h0,
  output logic pdet = 1'b1
);
  // result, operand and flag leave together so the cascade stays aligned
  always @(posedge clk)
  begin
    if (load)
    begin
      pc <= val;
      ac <= val[24:0];
      pdet <= (val == 48'h0);
    end
  end
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench of the multiply-accumulate slice
// Assumes: default pipeline depth, pattern 0 and mask 0
// Notes: fixed waits cover the three-stage operand-to-result latency
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic rst_sync = 1'b0;
  mac_slice_pkg::ctrl_s ctrl = '0;
  mac_slice_pkg::ce_s ce = '0;
  logic [24:0] a_in = 25'h0;
  logic [24:0] d_in = 25'h0;
  logic [17:0] b_in = 18'h0;
  logic [47:0] c_in = 48'h0;
  logic [47:0] nb_val = 48'h0;
  logic [47:0] pcin, p_out, pcout;
  logic [24:0] acin, acout;
  logic [17:0] bcout;
  logic pdet_in, pdet, pdet_wide;
  int fail_count = 0;
  int n_compared = 0;

  always #4 sys_clk = ~sys_clk;

  nbr_slice u_nbr_slice (.clk(sys_clk), .load(1'b1), .val(nb_val), .pc(pcin), .ac(acin),
    .pdet(pdet_in));
  mac_slice u_mac_slice (.SYS_CLK(sys_clk), .RESETN(resetn), .RST_SYNC(rst_sync), .CTRL(ctrl),
    .CE(ce), .A_IN(a_in), .D_IN(d_in), .B_IN(b_in), .C_IN(c_in), .ACIN(acin), .PCIN(pcin),
    .PDET_CASC_IN(pdet_in), .P_OUT(p_out), .PCOUT(pcout), .ACOUT(acout), .BCOUT(bcout),
    .PDET_OUT(pdet), .PDET_WIDE_OUT(pdet_wide));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // controls change together so the fabric keeps them in step with operands
  task automatic mode(input logic byp, input mac_slice_pkg::zsel_e z,
    input mac_slice_pkg::alu_op_e o, input mac_slice_pkg::simd_e s,
    input mac_slice_pkg::logic_fn_e f, input logic [4:0] e);
    @(posedge sys_clk);
    ctrl.mul_bypass <= byp;
    ctrl.zsel <= z;
    ctrl.op <= o;
    ctrl.simd <= s;
    ctrl.logic_fn <= f;
    ce <= e;
  endtask

  // holds operands long enough to flow through all stages
  task automatic drive(input logic byp, input mac_slice_pkg::zsel_e z,
    input mac_slice_pkg::alu_op_e o, input mac_slice_pkg::simd_e s,
    input mac_slice_pkg::logic_fn_e f, input logic [24:0] a, input logic [17:0] b,
    input logic [47:0] c);
    mode(byp, z, o, s, f, 5'h1F);
    a_in <= a;
    b_in <= b;
    c_in <= c;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic bypass(input mac_slice_pkg::simd_e s, input mac_slice_pkg::alu_op_e o,
    input mac_slice_pkg::logic_fn_e f, input logic [47:0] c);
    drive(1'b1, mac_slice_pkg::Z_CIN, o, s, f, 25'h0040040, 18'h01001, c);
  endtask

  task automatic pulse_p();
    @(posedge sys_clk);
    ce.ce_p <= 1'b1;
    @(posedge sys_clk);
    ce.ce_p <= 1'b0;
    #1;
  endtask

  // enables are dropped with the clear so no stale stage reloads after it
  task automatic clr();
    @(posedge sys_clk);
    rst_sync <= 1'b1;
    ce <= 5'h00;
    @(posedge sys_clk);
    rst_sync <= 1'b0;
    #1;
    chk(p_out, 48'h0);
    chk(pdet, 48'h1);
  endtask

  function automatic logic [47:0] lf(input int f, input logic [47:0] x, input logic [47:0] z);
    case (f)
      0: return x & z;
      1: return x | z;
      2: return x ^ z;
      3: return ~(x ^ z);
      4: return ~(x & z);
      5: return ~(x | z);
      6: return x & ~z;
      7: return x | ~z;
      8: return ~x;
      default: return x;
    endcase
  endfunction

  task automatic t_mul();
    drive(1'b0, mac_slice_pkg::Z_ZERO, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h1FFFFFD, 18'h00005, 48'h0);
    chk(p_out, 48'hFFFFFFFFFFF1);
    chk(pcout, 48'hFFFFFFFFFFF1);
    chk(acout, 48'h1FFFFFD);
    chk(bcout, 48'h5);
    drive(1'b0, mac_slice_pkg::Z_ZERO, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h1000000, 18'h20000, 48'h0);
    chk(p_out, 48'h020000000000);
  endtask

  task automatic t_pre();
    @(posedge sys_clk);
    ctrl.preadd_en <= 1'b1;
    d_in <= 25'h000000A;
    drive(1'b0, mac_slice_pkg::Z_ZERO, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h1FFFFFD, 18'h00007, 48'h0);
    chk(p_out, 48'h31);
    @(posedge sys_clk);
    ctrl.preadd_sub <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(p_out, 48'h5B);
    @(posedge sys_clk);
    ctrl.preadd_en <= 1'b0;
    ctrl.preadd_sub <= 1'b0;
  endtask

  task automatic t_alu();
    bypass(mac_slice_pkg::SIMD_FOUR12, mac_slice_pkg::OP_ADD, mac_slice_pkg::LF_AND, '1);
    chk(p_out, 48'h0);
    chk(pdet, 48'h1);
    bypass(mac_slice_pkg::SIMD_TWO24, mac_slice_pkg::OP_ADD, mac_slice_pkg::LF_AND, '1);
    chk(p_out, 48'h001000001000);
    bypass(mac_slice_pkg::SIMD_ONE48, mac_slice_pkg::OP_ADD, mac_slice_pkg::LF_AND, '1);
    chk(p_out, 48'h001001001000);
    chk(pdet, 48'h0);
    bypass(mac_slice_pkg::SIMD_FOUR12, mac_slice_pkg::OP_SUB, mac_slice_pkg::LF_AND, 48'h0);
    chk(p_out, 48'hFFFFFFFFFFFF);
    // negative a: the joined operand must be sign-extended to 48 bits
    drive(1'b1, mac_slice_pkg::Z_ZERO, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h1040040, 18'h01001, 48'h0);
    chk(p_out, 48'hFC1001001001);
    for (int i = 0; i < 10; i++)
    begin
      bypass(mac_slice_pkg::SIMD_ONE48, mac_slice_pkg::OP_LOGIC,
        mac_slice_pkg::logic_fn_e'(i), 48'h0F0F00FF0F0F);
      chk(p_out, lf(i, 48'h001001001001, 48'h0F0F00FF0F0F));
    end
  endtask

  // product held ready while the result stage is gated
  task automatic t_acc();
    clr();
    mode(1'b0, mac_slice_pkg::Z_ACC, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 5'h1E);
    a_in <= 25'h0000003;
    b_in <= 18'h00007;
    repeat (3) @(posedge sys_clk);
    pulse_p();
    chk(p_out, 48'h15);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(p_out, 48'h15);
    pulse_p();
    chk(p_out, 48'h2A);
    clr();
    // enable held for three edges so back-to-back steps are exercised
    mode(1'b0, mac_slice_pkg::Z_ACC, mac_slice_pkg::OP_CNT_UP, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 5'h01);
    repeat (2) @(posedge sys_clk);
    mode(1'b0, mac_slice_pkg::Z_ACC, mac_slice_pkg::OP_CNT_UP, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 5'h00);
    #1;
    chk(p_out, 48'h3);
    mode(1'b0, mac_slice_pkg::Z_ACC, mac_slice_pkg::OP_CNT_DN, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 5'h00);
    repeat (4) pulse_p();
    chk(p_out, 48'hFFFFFFFFFFFF);
  endtask

  task automatic t_casc();
    @(posedge sys_clk);
    nb_val <= 48'h123456789ABC;
    drive(1'b0, mac_slice_pkg::Z_CASC, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h0000002, 18'h00003, 48'h0);
    chk(p_out, 48'h123456789AC2);
    @(posedge sys_clk);
    nb_val <= 48'h0;
    drive(1'b0, mac_slice_pkg::Z_CASC, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h0, 18'h00005, 48'h0);
    chk(pdet_wide, 48'h1);
    @(posedge sys_clk);
    nb_val <= 48'h1;
    drive(1'b0, mac_slice_pkg::Z_CASC, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h1FFFFFF, 18'h00001, 48'h0);
    chk(pdet, 48'h1);
    chk(pdet_wide, 48'h0);
    // a comes over the neighbour's bus while the local a input stays zero
    @(posedge sys_clk);
    ctrl.a_casc <= 1'b1;
    nb_val <= 48'h000000000003;
    drive(1'b0, mac_slice_pkg::Z_ZERO, mac_slice_pkg::OP_ADD, mac_slice_pkg::SIMD_ONE48,
      mac_slice_pkg::LF_AND, 25'h0, 18'h00005, 48'h0);
    chk(p_out, 48'hF);
    chk(acout, 48'h3);
  endtask

  // a hang ends the run through the same report
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(p_out, 48'h0);
    t_mul();
    t_pre();
    t_alu();
    t_acc();
    t_casc();
    summarize();
  end
endmodule
